// >>> mmb_pkg.sv
// Shared constants, types and the register map of the MII MAC DMA port.
// Assumes a 32-bit APB slave whose byte address is 12 bits wide.
package mmb_pkg;
	// ----------------------------------------------------------------
	// Register map.
	// ----------------------------------------------------------------
	localparam int         NBUF       = 4;
	localparam logic [11:0] TX_BASE   = 12'h000;
	localparam logic [11:0] RX_BASE   = 12'h100;
	localparam logic [3:0]  OFS_STAT  = 4'h0;
	localparam logic [3:0]  OFS_ADDR  = 4'h4;
	localparam logic [3:0]  OFS_LEN   = 4'h8;
	localparam logic [11:0] CTRL_OFS  = 12'h200;
	localparam logic [11:0] MDATA_OFS = 12'h204;
	localparam logic [11:0] MCTRL_OFS = 12'h208;
	// ----------------------------------------------------------------
	// Field positions, widths and reset values.
	// ----------------------------------------------------------------
	localparam int          BIT_EN    = 0;
	localparam int          BIT_DN    = 1;
	localparam int          ADDR_LSB  = 5;
	localparam int          LEN_W     = 14;
	localparam int          CTRL_FDX  = 0;
	localparam int          CTRL_JMB  = 1;
	localparam int          MBUSY_BIT = 31;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam int          MDC_DIV   = 160;
	// ----------------------------------------------------------------
	// Types.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic [3:0] nib;
	} mmb_nib_t;
	typedef struct packed {
		logic        req;
		logic [31:0] addr;
		logic [31:0] data;
	} mmb_mreq_t;
	typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SEND, TX_END} mmb_tx_st_t;
endpackage

// >>> mmb_sync.sv
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; words are not kept coherent.
`timescale 1ns/1ps
`default_nettype none
module mmb_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Levels.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;

	// The first stage feeds only the second, so metastability stays put.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			q    <= '0;
		end else begin
			s1_q <= d;
			q    <= s1_q;
		end
	end
endmodule
`default_nettype wire

// >>> mmb_mgmt.sv
// Management clock divider and serial shifter for the data line.
// Assumes mgmt_in is already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none
module mmb_mgmt
	import mmb_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Command side.
	input  wire logic        start,
	input  wire logic [31:0] wdata,
	input  wire logic [5:0]  drive_len,
	output logic             busy,
	output logic      [31:0] rdata,
	// Pins.
	output logic             mgmt_clock_out,
	input  wire logic        mgmt_in,
	output logic             mgmt_out,
	output logic             mgmt_oe
);
	import mmb_pkg::*;
	localparam logic [7:0] HALF = 8'(MDC_DIV / 2 - 1);
	logic [7:0]  div_q, div_d;
	logic        mdc_q, mdc_d, act_q, act_d, out_q, out_d, oe_q, oe_d;
	logic [31:0] sh_q, sh_d;
	logic [5:0]  bit_q, bit_d, drv_q, drv_d;
	logic        tick;

	// Clock toggles every half period; data moves on its edges.
	always_comb begin
		tick  = (div_q == HALF);
		div_d = tick ? 8'h00 : div_q + 8'h01;
		mdc_d = tick ? ~mdc_q : mdc_q;
		act_d = act_q;
		out_d = out_q;
		oe_d  = oe_q;
		sh_d  = sh_q;
		bit_d = bit_q;
		drv_d = drv_q;
		if (start && !act_q) begin
			act_d = 1'b1;
			sh_d  = wdata;
			bit_d = 6'h20;
			drv_d = drive_len;
		end else if (tick && act_q && mdc_q) begin
			// Falling edge: present the next bit or release the line.
			if (bit_q == 6'h00) begin
				act_d = 1'b0;
				oe_d  = 1'b0;
			end else begin
				out_d = sh_q[31];
				oe_d  = (6'h20 - bit_q) < drv_q; // RQ11
				bit_d = bit_q - 6'h01;
			end
		end else if (tick && act_q && !mdc_q && bit_q != 6'h20) begin
			sh_d = {sh_q[30:0], mgmt_in}; // RQ11
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 8'h00;
			mdc_q <= 1'b0;
			act_q <= 1'b0;
			out_q <= 1'b0;
			oe_q  <= 1'b0;
			sh_q  <= RST_WORD;
			bit_q <= 6'h00;
			drv_q <= 6'h00;
		end else begin
			div_q <= div_d;
			mdc_q <= mdc_d;
			act_q <= act_d;
			out_q <= out_d;
			oe_q  <= oe_d;
			sh_q  <= sh_d;
			bit_q <= bit_d;
			drv_q <= drv_d;
		end
	end

	assign mgmt_clock_out = mdc_q;
	assign mgmt_out       = out_q;
	assign mgmt_oe        = oe_q;
	assign busy           = act_q;
	assign rdata          = sh_q;

	property p_mdc_div;
		@(posedge pclk) disable iff (!presetn)
		$changed(mdc_q) |-> $past(div_q) == HALF;
	endproperty
	a_mdc_div: assert property (p_mdc_div) // RQ10
		else $error("Management clock edge off the divide point.");
	property p_oe_act;
		@(posedge pclk) disable iff (!presetn)
		mgmt_oe |-> act_q;
	endproperty
	a_oe_act: assert property (p_oe_act) // RQ11
		else $error("Data line driven outside a transfer.");
endmodule
`default_nettype wire

// >>> mmb_mac.sv
// MII side and buffer DMA sequencer of the Ethernet MAC port.
// Assumes an APB master, single-cycle-ready memory ports and a PHY.
//
// Behaviour
// RQ1: PHY supplies continuous transmit nibble clock.
// RQ2: Transmit valid high only for data nibbles.
// RQ3: One nibble per transmit clock period.
// RQ4: PHY supplies receive clock at quarter rate.
// RQ5: PHY holds receive valid across frame.
// RQ6: Capture nibbles only while receive valid.
// RQ7: Carrier sense treated as asynchronous.
// RQ8: Collision treated as asynchronous.
// RQ9: Full duplex ignores collision input.
// RQ10: Management clock is bus clock over 160.
// RQ11: Management data line bidirectional, clocked by MAC.
// RQ12: Four transmit and four receive buffers.
// RQ13: Interrupt is OR of all done flags.
// RQ14: Software writes length, then address and enable.
// RQ15: Transmit done visible by poll or interrupt.
// RQ16: Status valid once done is set.
// RQ17: Software enables four distinct receive buffers.
// RQ18: Software leaves enabled receive buffers alone.
// RQ19: Second MAC needs its shared pins assigned.
// RQ20: Done is sticky until software clears it.
// RQ21: Address rewritten for every transfer.
// RQ22: Length at most 0x800, jumbo 0x2800.
// RQ23: Carrier and collision pass a synchroniser.
`timescale 1ns/1ps
`default_nettype none
module mmb_mac
	import mmb_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// MII pins.
	input  wire logic        tx_nibble_clock,
	output mmb_pkg::mmb_nib_t tx_nibble,
	input  wire logic        rx_nibble_clock,
	input  wire logic        rx_nibble_valid,
	input  wire logic [3:0]  rx_nibble_bus,
	input  wire logic        carrier_sense_in,
	input  wire logic        collision_in,
	// Management pins.
	output logic             mgmt_clock_out,
	input  wire logic        mgmt_data_in,
	output logic             mgmt_data_out,
	output logic             mgmt_data_oe,
	// Memory ports.
	output mmb_pkg::mmb_mreq_t txm,
	input  wire logic        txm_ack,
	input  wire logic [31:0] txm_rdata,
	output mmb_pkg::mmb_mreq_t rxm,
	input  wire logic        rxm_ack,
	// Interrupt.
	output logic             dma_irq
);
	import mmb_pkg::*;
	// ----------------------------------------------------------------
	// Pin synchronisers and edge events.
	// ----------------------------------------------------------------
	logic [9:0] syn;
	logic s_txc, s_rxc, s_dv, s_crs, s_col, s_mdi, txc_q, rxc_q;
	logic [3:0] s_rxd;
	logic tx_fall, rx_take;

	mmb_sync #(.W(10)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({tx_nibble_clock, rx_nibble_clock, rx_nibble_valid,
			rx_nibble_bus, carrier_sense_in, collision_in,
			mgmt_data_in}),
		.q(syn)
	); // RQ23
	assign {s_txc, s_rxc, s_dv, s_rxd, s_crs, s_col, s_mdi} = syn;

	// Edges are found on the synchronised copies; mid-period falls are
	// used so that data is stable on both sides.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txc_q <= 1'b0;
			rxc_q <= 1'b0;
		end else begin
			txc_q <= s_txc;
			rxc_q <= s_rxc;
		end
	end
	assign tx_fall = txc_q & ~s_txc;
	assign rx_take = rxc_q & ~s_rxc;

	// ----------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------
	logic [26:0] tadr_q [NBUF], tadr_d [NBUF], radr_q [NBUF], radr_d [NBUF];
	logic [LEN_W-1:0] tlen_q [NBUF], tlen_d [NBUF];
	logic [31:0] tsta_q [NBUF], tsta_d [NBUF], rsta_q [NBUF], rsta_d [NBUF];
	logic [NBUF-1:0] ten_q, ten_d, tdn_q, tdn_d, ren_q, ren_d, rdn_q, rdn_d;
	logic [1:0]  ctl_q, ctl_d;
	logic [31:0] mdat_q, mdat_d, prd_q, prd_d, rmux;
	logic        irq_q, wr, mstart, mbusy, hit;
	logic [31:0] mrd;
	logic [1:0]  bi;
	// Engine events consumed by the register file.
	logic        tfin, rfin;
	logic [31:0] tfin_sta, rfin_sta;
	logic [1:0]  tcur_q, tcur_d, rcur_q, rcur_d;

	assign wr = psel & penable & pwrite;
	assign bi = paddr[5:4];
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// Decode and read mux; unmapped words read zero and flag an error.
	always_comb begin
		hit  = 1'b1;
		rmux = RST_WORD;
		if (paddr[11:8] == TX_BASE[11:8] && paddr[7:6] == 2'b00) begin
			case (paddr[3:0])
				OFS_STAT: rmux = tsta_q[bi];
				OFS_ADDR: rmux = {tadr_q[bi], 1'b0, tcur_q, tdn_q[bi], ten_q[bi]};
				OFS_LEN:  rmux = {18'h0, tlen_q[bi]};
				default:  hit = 1'b0;
			endcase
		end else if (paddr[11:8] == RX_BASE[11:8] && paddr[7:6] == 2'b00) begin
			case (paddr[3:0])
				OFS_STAT: rmux = rsta_q[bi];
				OFS_ADDR: rmux = {radr_q[bi], 1'b0, rcur_q, rdn_q[bi], ren_q[bi]};
				default:  hit = 1'b0;
			endcase
		end else begin
			case (paddr)
				CTRL_OFS:  rmux = {30'h0, ctl_q};
				MDATA_OFS: rmux = mrd;
				MCTRL_OFS: rmux = {mbusy, 31'h0};
				default:   hit = 1'b0;
			endcase
		end
	end

	// Register writes and hardware events. A done set in the same cycle
	// as a software clear wins, so no completion is ever lost.
	always_comb begin
		tadr_d = tadr_q;
		tlen_d = tlen_q;
		tsta_d = tsta_q;
		radr_d = radr_q;
		rsta_d = rsta_q;
		ten_d  = ten_q;
		tdn_d  = tdn_q;
		ren_d  = ren_q;
		rdn_d  = rdn_q;
		ctl_d  = ctl_q;
		mdat_d = mdat_q;
		mstart = 1'b0;
		prd_d  = (psel && !penable) ? rmux : prd_q;
		if (wr && hit) begin
			if (paddr[11:8] == TX_BASE[11:8] && paddr[3:0] == OFS_ADDR) begin
				tadr_d[bi] = pwdata[31:ADDR_LSB]; // RQ14
				ten_d[bi]  = pwdata[BIT_EN];
				tdn_d[bi]  = tdn_q[bi] & pwdata[BIT_DN]; // RQ20
			end else if (paddr[11:8] == TX_BASE[11:8] && paddr[3:0] == OFS_LEN) begin
				tlen_d[bi] = pwdata[LEN_W-1:0];
			end else if (paddr[11:8] == RX_BASE[11:8] && paddr[3:0] == OFS_ADDR) begin
				radr_d[bi] = pwdata[31:ADDR_LSB];
				ren_d[bi]  = pwdata[BIT_EN];
				rdn_d[bi]  = rdn_q[bi] & pwdata[BIT_DN]; // RQ20
			end else if (paddr == CTRL_OFS) begin
				ctl_d = pwdata[1:0];
			end else if (paddr == MDATA_OFS) begin
				mdat_d = pwdata;
			end else if (paddr == MCTRL_OFS) begin
				mstart = 1'b1;
			end
		end
		if (tfin) begin
			tdn_d[tcur_q]  = 1'b1; // RQ15
			ten_d[tcur_q]  = 1'b0;
			tsta_d[tcur_q] = tfin_sta; // RQ16
		end
		if (rfin) begin
			rdn_d[rcur_q]  = 1'b1;
			ren_d[rcur_q]  = 1'b0;
			rsta_d[rcur_q] = rfin_sta;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NBUF; i++) begin
				tadr_q[i] <= 27'h0;
				radr_q[i] <= 27'h0;
				tlen_q[i] <= 14'h0;
				tsta_q[i] <= RST_WORD;
				rsta_q[i] <= RST_WORD;
			end
			ten_q  <= 4'h0;
			tdn_q  <= 4'h0;
			ren_q  <= 4'h0;
			rdn_q  <= 4'h0;
			ctl_q  <= 2'h0;
			mdat_q <= RST_WORD;
			prd_q  <= RST_WORD;
			irq_q  <= 1'b0;
		end else begin
			tadr_q <= tadr_d;
			radr_q <= radr_d;
			tlen_q <= tlen_d;
			tsta_q <= tsta_d;
			rsta_q <= rsta_d;
			ten_q  <= ten_d;
			tdn_q  <= tdn_d;
			ren_q  <= ren_d;
			rdn_q  <= rdn_d;
			ctl_q  <= ctl_d;
			mdat_q <= mdat_d;
			prd_q  <= prd_d;
			irq_q  <= |{tdn_d, rdn_d}; // RQ13
		end
	end
	assign prdata  = prd_q;
	assign dma_irq = irq_q;

	mmb_mgmt u_mgmt (
		.pclk(pclk),
		.presetn(presetn),
		.start(mstart),
		.wdata(mdat_q),
		.drive_len(pwdata[5:0]),
		.busy(mbusy),
		.rdata(mrd),
		.mgmt_clock_out(mgmt_clock_out),
		.mgmt_in(s_mdi),
		.mgmt_out(mgmt_data_out),
		.mgmt_oe(mgmt_data_oe)
	);

	// ----------------------------------------------------------------
	// Transmit sequencer.
	// ----------------------------------------------------------------
	mmb_tx_st_t  tst_q, tst_d;
	logic [31:0] tma_q, tma_d, tw_q, tw_d, tsr_q, tsr_d;
	logic [14:0] tnib_q, tnib_d;
	logic [3:0]  tn_q, tn_d;
	mmb_nib_t    tout_q, tout_d;
	logic        fdx;

	assign fdx = ctl_q[CTRL_FDX];

	// Buffers are served in ring order; a collision in half duplex or a
	// late memory word aborts the frame, since nothing is buffered.
	always_comb begin
		tst_d    = tst_q;
		tma_d    = tma_q;
		tw_d     = tw_q;
		tsr_d    = tsr_q;
		tnib_d   = tnib_q;
		tn_d     = tn_q;
		tout_d   = tout_q;
		tcur_d   = tcur_q;
		tfin     = 1'b0;
		tfin_sta = tsr_q;
		case (tst_q)
			TX_IDLE: begin
				if (ten_q[tcur_q] && (fdx || !s_crs)) begin // RQ7
					tma_d  = {tadr_q[tcur_q], 5'h00};
					tnib_d = {tlen_q[tcur_q], 1'b0};
					tsr_d  = RST_WORD;
					tst_d  = (tlen_q[tcur_q] == 14'h0) ? TX_END : TX_FETCH;
				end
			end
			TX_FETCH: begin
				if (txm_ack) begin
					tw_d  = txm_rdata;
					tn_d  = 4'h8;
					tma_d = tma_q + 32'h4;
					tst_d = TX_SEND;
				end else if (tx_fall && tout_q.valid) begin
					tout_d.valid = 1'b0;
					tsr_d  = 32'h5;
					tst_d  = TX_END;
				end
			end
			TX_SEND: begin
				if (tx_fall) begin
					if (s_col && !fdx) begin // RQ8 RQ9
						tout_d.valid = 1'b0;
						tsr_d  = 32'h3;
						tst_d  = TX_END;
					end else begin
						tout_d = '{valid: 1'b1, nib: tw_q[3:0]}; // RQ2 RQ3
						tw_d   = {4'h0, tw_q[31:4]};
						tnib_d = tnib_q - 15'h1;
						tn_d   = tn_q - 4'h1;
						if (tnib_q == 15'h1) begin
							tst_d = TX_END;
						end else if (tn_q == 4'h1) begin
							tst_d = TX_FETCH;
						end
					end
				end
			end
			TX_END: begin
				if (tx_fall || !tout_q.valid) begin
					tout_d.valid = 1'b0; // RQ2
					tfin   = 1'b1;
					tcur_d = tcur_q + 2'h1; // RQ12
					tst_d  = TX_IDLE;
				end
			end
			default: tst_d = TX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tst_q  <= TX_IDLE;
			tma_q  <= RST_WORD;
			tw_q   <= RST_WORD;
			tsr_q  <= RST_WORD;
			tnib_q <= 15'h0;
			tn_q   <= 4'h0;
			tout_q <= '0;
			tcur_q <= 2'h0;
		end else begin
			tst_q  <= tst_d;
			tma_q  <= tma_d;
			tw_q   <= tw_d;
			tsr_q  <= tsr_d;
			tnib_q <= tnib_d;
			tn_q   <= tn_d;
			tout_q <= tout_d;
			tcur_q <= tcur_d;
		end
	end
	assign tx_nibble = tout_q;
	assign txm = '{req: tst_q == TX_FETCH, addr: tma_q, data: RST_WORD};

	// ----------------------------------------------------------------
	// Receive sequencer.
	// ----------------------------------------------------------------
	logic        ract_q, ract_d, rprv_q, rprv_d, rovr_q, rovr_d;
	logic [31:0] rw_q, rw_d, rma_q, rma_d;
	logic [3:0]  rn_q, rn_d;
	logic [14:0] rcnt_q, rcnt_d;
	mmb_mreq_t   rxm_q, rxm_d;

	// Only one store may be pending; a word completing before the last
	// store was taken is an overrun, reported in the status word.
	always_comb begin
		ract_d   = ract_q;
		rprv_d   = rprv_q;
		rovr_d   = rovr_q;
		rw_d     = rw_q;
		rma_d    = rma_q;
		rn_d     = rn_q;
		rcnt_d   = rcnt_q;
		rcur_d   = rcur_q;
		rfin     = 1'b0;
		rfin_sta = {14'h0, rcnt_q[0], rovr_q, 2'h0, rcnt_q[14:1]};
		rxm_d    = rxm_q;
		if (rxm_ack) begin
			rxm_d.req = 1'b0;
		end
		if (rx_take) begin
			rprv_d = s_dv;
			if (s_dv && ract_q) begin // RQ6
				rw_d   = {s_rxd, rw_q[31:4]};
				rn_d   = rn_q + 4'h1;
				rcnt_d = rcnt_q + 15'h1;
				if (rn_q == 4'h7) begin
					rovr_d = rovr_q | (rxm_q.req & ~rxm_ack);
					rxm_d  = '{req: 1'b1, addr: rma_q, data: rw_d};
					rma_d  = rma_q + 32'h4;
					rn_d   = 4'h0;
				end
			end else if (s_dv && !rprv_q && ren_q[rcur_q]) begin
				ract_d = 1'b1;
				rma_d  = {radr_q[rcur_q], 5'h00};
				rw_d   = {s_rxd, 28'h0};
				rn_d   = 4'h1;
				rcnt_d = 15'h1;
				rovr_d = 1'b0;
			end else if (!s_dv && ract_q) begin
				if (rn_q != 4'h0) begin
					rovr_d = rovr_q | (rxm_q.req & ~rxm_ack);
					rxm_d  = '{req: 1'b1, addr: rma_q,
						data: rw_q >> {5'(4'h8 - rn_q), 2'b00}};
				end
				ract_d = 1'b0;
				rfin   = 1'b1;
				rfin_sta = {14'h0, rcnt_q[0], rovr_d, 2'h0, rcnt_q[14:1]};
				rcur_d = rcur_q + 2'h1; // RQ12
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ract_q <= 1'b0;
			rprv_q <= 1'b0;
			rovr_q <= 1'b0;
			rw_q   <= RST_WORD;
			rma_q  <= RST_WORD;
			rn_q   <= 4'h0;
			rcnt_q <= 15'h0;
			rcur_q <= 2'h0;
			rxm_q  <= '0;
		end else begin
			ract_q <= ract_d;
			rprv_q <= rprv_d;
			rovr_q <= rovr_d;
			rw_q   <= rw_d;
			rma_q  <= rma_d;
			rn_q   <= rn_d;
			rcnt_q <= rcnt_d;
			rcur_q <= rcur_d;
			rxm_q  <= rxm_d;
		end
	end
	assign rxm = rxm_q;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	property p_txv_edge;
		@(posedge pclk) disable iff (!presetn)
		$rose(tx_nibble.valid) |-> $past(tx_fall);
	endproperty
	a_txv_edge: assert property (p_txv_edge) // RQ2
		else $error("Transmit valid rose off a clock fall.");
	property p_txd_edge;
		@(posedge pclk) disable iff (!presetn)
		$changed(tx_nibble.nib) |-> $past(tx_fall) && tx_nibble.valid;
	endproperty
	a_txd_edge: assert property (p_txd_edge) // RQ3
		else $error("Transmit nibble changed off a clock fall.");
	property p_rx_take;
		@(posedge pclk) disable iff (!presetn)
		rx_take && s_dv && ract_q |=> rcnt_q == $past(rcnt_q) + 15'h1;
	endproperty
	a_rx_take: assert property (p_rx_take) // RQ6
		else $error("Valid receive nibble not counted.");
	property p_fdx_col;
		@(posedge pclk) disable iff (!presetn)
		tx_fall && tst_q == TX_SEND && fdx && tnib_q > 15'h1 && tn_q > 4'h1
			|=> tst_q == TX_SEND && tx_nibble.valid;
	endproperty
	a_fdx_col: assert property (p_fdx_col) // RQ9
		else $error("Full duplex frame left the send state early.");
	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		dma_irq == |{tdn_q, rdn_q};
	endproperty
	a_irq: assert property (p_irq) // RQ13
		else $error("Interrupt does not match the done flags.");
	property p_dn_set;
		@(posedge pclk) disable iff (!presetn)
		tfin |=> tdn_q[$past(tcur_q)] && !ten_q[$past(tcur_q)];
	endproperty
	a_dn_set: assert property (p_dn_set) // RQ15
		else $error("Transmit done not set on completion.");
	property p_dn_hold;
		@(posedge pclk) disable iff (!presetn)
		tdn_q[0] && !(wr && paddr == (TX_BASE | 12'(OFS_ADDR))) |=> tdn_q[0];
	endproperty
	a_dn_hold: assert property (p_dn_hold) // RQ20
		else $error("Done flag dropped without a software clear.");
	property p_ring;
		@(posedge pclk) disable iff (!presetn)
		rfin |=> rcur_q == $past(rcur_q) + 2'h1 ##1 !rfin;
	endproperty
	a_ring: assert property (p_ring) // RQ12
		else $error("Receive buffer ring did not advance.");
endmodule
`default_nettype wire

// >>> mmb_phy.sv
// PHY and buffer memory model facing the MAC port.
// Assumes the mmb_mac port names and a 200 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module mmb_phy
	import mmb_pkg::*;
(
	// Clock and reset.
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Memory ports.
	input  wire mmb_pkg::mmb_mreq_t txm,
	output logic                    txm_ack,
	output logic             [31:0] txm_rdata,
	input  wire mmb_pkg::mmb_mreq_t rxm,
	output logic                    rxm_ack,
	// PHY pins.
	output logic                    tx_nibble_clock,
	output logic                    rx_nibble_clock,
	input  wire logic               mgmt_data_oe,
	input  wire logic               mgmt_data_out,
	output logic                    mgmt_data_in
);
	// Transmit clock runs free at the link rate.
	initial begin
		tx_nibble_clock = 1'b0;
		forever #40 tx_nibble_clock = ~tx_nibble_clock;
	end
	// Receive clock also runs free at the same period, offset by 13 ns from the transmit clock.
	initial begin
		rx_nibble_clock = 1'b0;
		#13;
		forever #40 rx_nibble_clock = ~rx_nibble_clock;
	end
	// One-cycle ack a cycle after each request, so req must be held.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txm_ack <= 1'b0;
			rxm_ack <= 1'b0;
		end else begin
			txm_ack <= txm.req & ~txm_ack;
			rxm_ack <= rxm.req & ~rxm_ack;
		end
	end
	// Read data is valid with ack only; otherwise it shows junk.
	assign txm_rdata = txm_ack ? txm.addr ^ 32'h5A5A_0F0F : ~txm.addr;
	// The line has a pull-up; the PHY itself never drives it here.
	assign mgmt_data_in = mgmt_data_oe ? mgmt_data_out : 1'b1;
endmodule
`default_nettype wire

// >>> mii_mac_dma_buffer_port_test.sv
// Self-checking bench for the MAC port with a PHY and memory model.
// Assumes mmb_mac, mmb_phy and mmb_pkg compiled before it.
`timescale 1ns/1ps
`default_nettype none
module mii_mac_dma_buffer_port_test;
	import mmb_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic        rx_nibble_valid = 1'b0;
	logic [3:0]  rx_nibble_bus = 4'h0;
	logic        carrier_sense_in = 1'b0;
	logic        collision_in = 1'b0;
	logic [31:0] prdata, txm_rdata, r, w;
	logic        pready, pslverr, slv, dma_irq, mgmt_clock_out;
	logic        tx_nibble_clock, rx_nibble_clock, txm_ack, rxm_ack;
	logic        mgmt_data_in, mgmt_data_out, mgmt_data_oe;
	mmb_nib_t    tx_nibble;
	mmb_mreq_t   txm, rxm;
	logic [3:0]  nq[$];
	logic [31:0] wq[$];
	int          miscompares = 0;
	int          compares = 0;
	int          cyc = 0;
	int          i;
	time         t0;

	always #2.5 pclk = ~pclk;

	mmb_mac dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .tx_nibble_clock,
		.tx_nibble, .rx_nibble_clock, .rx_nibble_valid, .rx_nibble_bus,
		.carrier_sense_in, .collision_in, .mgmt_clock_out, .mgmt_data_in,
		.mgmt_data_out, .mgmt_data_oe, .txm, .txm_ack, .txm_rdata, .rxm,
		.rxm_ack, .dma_irq);
	mmb_phy phy (.pclk, .presetn, .txm, .txm_ack, .txm_rdata, .rxm,
		.rxm_ack, .tx_nibble_clock, .rx_nibble_clock, .mgmt_data_oe,
		.mgmt_data_out, .mgmt_data_in);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic poll(input logic [11:0] a, input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while (r[b] !== v && n < 3000);
	endtask

	// Random nibbles, low first into words, aligned to the rx clock.
	task automatic rx_frame(input int n);
		logic [31:0] x;
		x = 32'h0;
		for (int k = 0; k < n; k++) begin
			@(posedge rx_nibble_clock);
			@(posedge pclk);
			x[4*(k%8)+:4] = 4'($urandom);
			rx_nibble_valid <= 1'b1;
			rx_nibble_bus <= x[4*(k%8)+:4];
			if (k % 8 == 7) begin
				wq.push_back(x);
				x = 32'h0;
			end
		end
		if (n % 8 != 0) wq.push_back(x);
		@(posedge rx_nibble_clock);
		@(posedge pclk);
		rx_nibble_valid <= 1'b0;
		rx_nibble_bus <= 4'($urandom); // Ignored while valid is low.
	endtask

	// Nibble monitor: valid nibbles take the oldest expectation.
	always @(posedge tx_nibble_clock) begin
		if (tx_nibble.valid === 1'b1) begin
			if (nq.size() == 0) chk(32'h1, 32'h0);
			else chk(32'(tx_nibble.nib), 32'(nq.pop_front()));
		end
	end

	// Store monitor: each acked store takes the oldest expected word.
	always @(posedge pclk) begin
		if (rxm.req === 1'b1 && rxm_ack === 1'b1) begin
			if (wq.size() == 0) chk(32'h1, 32'h0);
			else chk(rxm.data, wq.pop_front());
		end
	end

	// A hang anywhere ends the run as a failure.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			$display("mismatch at %0t: timeout", $time);
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		i = $urandom(32'hB917EAD5);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, TX_BASE + 12'(OFS_ADDR), 32'h0);
		chk(r, RST_WORD);
		apb(1'b0, 12'h300, 32'h0);
		chk(32'(slv), 32'h1);
		chk(r, 32'h0);
		// Each of the four slots of each direction reads back the value just written to it.
		for (int k = 0; k < NBUF; k++) begin
			w = $urandom & 32'h0000_07FF;
			apb(1'b1, TX_BASE + 12'(16*k) + 12'(OFS_LEN), w);
			apb(1'b0, TX_BASE + 12'(16*k) + 12'(OFS_LEN), 32'h0);
			chk(r, w);
			w = ($urandom & 32'hFFFF_FF00) | 32'(k << 5) | 32'h1;
			apb(1'b1, RX_BASE + 12'(16*k) + 12'(OFS_ADDR), w);
			apb(1'b0, RX_BASE + 12'(16*k) + 12'(OFS_ADDR), 32'h0);
			chk(r, w);
		end
		@(posedge mgmt_clock_out);
		t0 = $time;
		@(posedge mgmt_clock_out);
		chk(32'(($time - t0) / 5), 32'(MDC_DIV));
		// Full duplex send of one word with collision and carrier up.
		collision_in <= 1'b1;
		carrier_sense_in <= 1'b1;
		apb(1'b1, CTRL_OFS, 32'h1);
		w = $urandom & 32'hFFFF_FFE0;
		for (i = 0; i < 8; i++)
			nq.push_back(4'((w ^ 32'h5A5A_0F0F) >> (4*i)));
		apb(1'b1, TX_BASE + 12'(OFS_LEN), 32'h4);
		apb(1'b1, TX_BASE + 12'(OFS_ADDR), w | 32'h1);
		poll(TX_BASE + 12'(OFS_ADDR), 1, 1'b1);
		chk(32'(r[1]), 32'h1);
		chk(32'(dma_irq), 32'h1);
		chk(32'(nq.size()), 32'h0);
		apb(1'b0, TX_BASE + 12'(OFS_STAT), 32'h0);
		chk(r, 32'h0);
		apb(1'b1, TX_BASE + 12'(OFS_ADDR), 32'h0);
		apb(1'b0, TX_BASE + 12'(OFS_ADDR), 32'h0);
		chk(32'(r[1]), 32'h0);
		chk(32'(dma_irq), 32'h0);
		// Half duplex with collision up: the frame aborts unsent.
		carrier_sense_in <= 1'b0;
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, TX_BASE + 12'h010 + 12'(OFS_LEN), 32'h4);
		apb(1'b1, TX_BASE + 12'h010 + 12'(OFS_ADDR), w | 32'h1);
		poll(TX_BASE + 12'h010 + 12'(OFS_ADDR), 1, 1'b1);
		apb(1'b0, TX_BASE + 12'h010 + 12'(OFS_STAT), 32'h0);
		chk(r, 32'h3);
		apb(1'b1, TX_BASE + 12'h010 + 12'(OFS_ADDR), 32'h0);
		// Receive of twelve nibbles: a full word then a partial one.
		collision_in <= 1'b0;
		rx_frame(12);
		poll(RX_BASE + 12'(OFS_ADDR), 1, 1'b1);
		chk(32'(dma_irq), 32'h1);
		apb(1'b0, RX_BASE + 12'(OFS_STAT), 32'h0);
		chk(r, 32'h6);
		chk(32'(wq.size()), 32'h0);
		// Management frame: 16 bits driven, the rest read back high.
		apb(1'b1, MDATA_OFS, 32'hC3A5_0000);
		apb(1'b1, MCTRL_OFS, 32'h10);
		apb(1'b0, MCTRL_OFS, 32'h0);
		chk(32'(r[MBUSY_BIT]), 32'h1);
		poll(MCTRL_OFS, MBUSY_BIT, 1'b0);
		apb(1'b0, MDATA_OFS, 32'h0);
		chk(r, 32'hC3A5_FFFF);
		end_of_test();
	end
endmodule
`default_nettype wire
